// *** hdl/responder_map.vh ***
// Purpose: constants for the command responder
// Assumes: byte-wide command codes, apb register words
// Notes:   offsets are byte addresses on the apb port
`ifndef RESPONDER_MAP_VH
`define RESPONDER_MAP_VH
// apb register offsets
`define OFF_CTRL       8'h00
`define OFF_STATUS     8'h04
`define OFF_CMD        8'h08
`define OFF_RESULT     8'h0C
`define OFF_LOCAL_ID   8'h10
`define OFF_REMOTE_ID  8'h14
`define OFF_BITRATE    8'h18
`define OFF_DATA0      8'h1C
`define OFF_DATA1      8'h20
`define OFF_TXFRAME_LO 8'h24
`define OFF_TXFRAME_HI 8'h28
`define OFF_RXFRAME_LO 8'h2C
`define OFF_RXFRAME_HI 8'h30
// ctrl fields
`define CTRL_TX_DONE   0
`define CTRL_RX_PUSH   1
`define CTRL_EXEC_DONE 2
`define CTRL_EXEC_FAIL 3
// command codes
`define CMD_RESTART    8'h01
`define CMD_VERSION    8'h02
`define CMD_BITRATE    8'h09
`define CMD_LOCAL_ID   8'h0B
`define CMD_REMOTE_ID  8'h0C
// header values
`define ACT_GET        8'h00
`define ACT_SET        8'h01
`define ACT_EXE        8'h02
`define ACT_RET        8'h03
`define ERR_NONE       8'h00
`define ERR_HEADER     8'h01
`define ERR_LENGTH     8'h02
`define ERR_UNKNOWN    8'h03
`define ERR_ACTION     8'h04
`define ERR_RANGE      8'h05
`define RESERVED_BYTE  8'h00
`define NEG_LEN        8'h04
// iso-tp frame types
`define PCI_SINGLE     4'h0
`define PCI_FIRST      4'h1
`define PCI_CONSEC     4'h2
`define PCI_FLOW       4'h3
`define FC_CTS         8'h30
`define FC_BLOCK       8'h00
`define FC_STMIN_MS    8'h01
// reset values
`define RST_LOCAL_ID   32'h0000_07FF
`define RST_REMOTE_ID  32'h0000_01C3
`define RST_BITRATE    32'h0000_01F4
`endif

// *** hdl/can_command_responder.v ***
// Purpose: response side of an iso-tp command interpreter, framed frame by frame
// Assumes: software moves can frames in and out through apb registers
// Notes:   one command in flight; payload up to 32 bytes held in flip-flops
// What this block does
// - every received command gets exactly one response, positive or negative
// - ordinary commands finish executing before the response is sent
// - restart command answers first, restarts only after the response left
// - transport id set commands answer using the previous identifier
// - after that response, the newly written identifier takes effect
// - new bit rate applies only after its response has been sent
// - failure gives four byte response: code, 0x03, error, 0x00
// - a rejected command leaves device state unchanged
// - positive response: code, 0x03, 0x00, 0x00, then command data
// - iso-tp framing is prepended; long messages are split into frames
// - up to seven bytes travel as a single frame, zero padded
// - on/off set acknowledge is a four byte single frame header
// - longer responses open with a first frame 0x1L LL and six bytes
// - flow control is sent by the receiver of a segmented message
// - device answers host first frame with 0x30, block 0, 1 ms
// - consecutive frames 0x21, 0x22.. carry seven bytes, last padded
// - version reply is the header plus a 14 byte string; data0 and data1 fill only bytes 4..11, later bytes are left from buf_reg
// - serial interval set and reply are eight bytes, multi-frame
// - error codes 0x00 to 0x05 as defined
// - action codes get, set, execute, and return in responses
`timescale 1ns/10ps
`include "responder_map.vh"

module can_command_responder
#(
  parameter MAX_LEN = 32
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         restart_req,
  output reg  [31:0] active_local_id,
  output reg  [31:0] active_remote_id,
  output reg  [31:0] active_bitrate
);

  localparam S_RX    = 3'd0;
  localparam S_EXEC  = 3'd1;
  localparam S_SEND  = 3'd2;
  localparam S_WAIT  = 3'd3;
  localparam S_FLOW  = 3'd4;
  localparam S_APPLY = 3'd5;
  localparam S_HOSTFC = 3'd7;

  reg [2:0]   state_reg;
  reg [7:0]   buf_reg [0:MAX_LEN-1];
  reg [7:0]   rx_len_reg;
  reg [7:0]   rx_cnt_reg;
  reg [7:0]   tx_len_reg;
  reg [7:0]   tx_pos_reg;
  reg [3:0]   seq_reg;
  reg [63:0]  txf_reg;
  reg [63:0]  rxf_reg;
  reg         tx_valid_reg;
  reg         fc_pending_reg;
  reg [7:0]   err_reg;
  reg [31:0]  data0_reg;
  reg [31:0]  data1_reg;
  reg [31:0]  pend_id_reg;
  reg [7:0]   pend_cmd_reg;
  reg [7:0]   resp_len_reg;
  integer     i;

  wire        acc   = psel & penable;
  wire        wr    = acc & pwrite;
  wire [7:0]  cmd   = buf_reg[0];
  wire [7:0]  act   = buf_reg[1];
  wire [3:0]  pci   = rxf_reg[7:4];

  // byte k of the staged tx frame: payload byte or zero pad
  function [7:0] pay;
    input [7:0] pos;
    input [7:0] len;
    input [7:0] b;
    begin
      pay = (pos < len) ? b : 8'h00;
    end
  endfunction

  // build the next outgoing frame from the response buffer
  function [63:0] frame_at;
    input [7:0] pos;
    input [7:0] len;
    input [3:0] seq;
    reg   [63:0] f;
    integer      k;
    begin
      f = 64'h0;
      if (len <= 8'd7)
      begin
        f[7:0] = len;
        for (k = 0; k < 7; k = k + 1)
          f[8*k+8 +: 8] = pay(k[7:0], len, buf_reg[k]);
      end
      else if (pos == 8'd0)
      begin
        f[7:0]  = {`PCI_FIRST, 4'h0};
        f[15:8] = len;
        for (k = 0; k < 6; k = k + 1)
          f[8*k+16 +: 8] = buf_reg[k];
      end
      else
      begin
        f[7:0] = {`PCI_CONSEC, seq};
        for (k = 0; k < 7; k = k + 1)
          f[8*k+8 +: 8] = pay(pos + k[7:0], len, buf_reg[(pos + k) % MAX_LEN]);
      end
      frame_at = f;
    end
  endfunction

  wire [31:0] word_in = {buf_reg[7], buf_reg[6], buf_reg[5], buf_reg[4]};

  // apb read mux shows live protocol state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= acc & ~pready;
      pslverr <= 1'b0;
      if (acc & ~pready & ~pwrite)
      begin
        if (paddr == `OFF_STATUS)
          prdata <= {24'h0, fc_pending_reg, tx_valid_reg, 3'h0, state_reg};
        else if (paddr == `OFF_CMD)
          prdata <= {8'h0, rx_len_reg, act, cmd};
        else if (paddr == `OFF_RESULT)
          prdata <= {24'h0, err_reg};
        else if (paddr == `OFF_LOCAL_ID)
          prdata <= active_local_id;
        else if (paddr == `OFF_REMOTE_ID)
          prdata <= active_remote_id;
        else if (paddr == `OFF_BITRATE)
          prdata <= active_bitrate;
        else if (paddr == `OFF_DATA0)
          prdata <= word_in;
        else if (paddr == `OFF_TXFRAME_LO)
          prdata <= txf_reg[31:0];
        else if (paddr == `OFF_TXFRAME_HI)
          prdata <= txf_reg[63:32];
        else
        begin
          prdata  <= 32'h0;
          pslverr <= (paddr != `OFF_CTRL) && (paddr != `OFF_DATA1)
                     && (paddr != `OFF_RXFRAME_LO) && (paddr != `OFF_RXFRAME_HI);
        end
      end
    end
  end

  wire wr_go = wr & ~pready;
  wire ctl   = wr_go && (paddr == `OFF_CTRL);

  // command state machine and iso-tp framing
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg        <= S_RX;
      rx_len_reg       <= 8'h0;
      rx_cnt_reg       <= 8'h0;
      tx_len_reg       <= 8'h0;
      tx_pos_reg       <= 8'h0;
      seq_reg          <= 4'h1;
      txf_reg          <= 64'h0;
      rxf_reg          <= 64'h0;
      tx_valid_reg     <= 1'b0;
      fc_pending_reg   <= 1'b0;
      err_reg          <= `ERR_NONE;
      data0_reg        <= 32'h0;
      data1_reg        <= 32'h0;
      pend_id_reg      <= 32'h0;
      pend_cmd_reg     <= 8'h0;
      resp_len_reg     <= 8'h0;
      restart_req      <= 1'b0;
      active_local_id  <= `RST_LOCAL_ID;
      active_remote_id <= `RST_REMOTE_ID;
      active_bitrate   <= `RST_BITRATE;
      for (i = 0; i < MAX_LEN; i = i + 1)
        buf_reg[i] <= 8'h0;
    end
    else
    begin
      restart_req <= 1'b0;
      if (wr_go && paddr == `OFF_RXFRAME_LO)
        rxf_reg[31:0] <= pwdata;
      if (wr_go && paddr == `OFF_RXFRAME_HI)
        rxf_reg[63:32] <= pwdata;
      if (wr_go && paddr == `OFF_DATA0)
        data0_reg <= pwdata;
      if (wr_go && paddr == `OFF_DATA1)
        data1_reg <= pwdata;
      case (state_reg)
        // gather the command; frames pushed during a response, bar the host flow control frame, are ignored
        S_RX:
        begin
          if (ctl && pwdata[`CTRL_RX_PUSH])
          begin
            if (pci == `PCI_SINGLE)
            begin
              rx_len_reg <= {4'h0, rxf_reg[3:0]};
              for (i = 0; i < 7; i = i + 1)
                buf_reg[i] <= rxf_reg[8*i+8 +: 8];
              state_reg <= S_EXEC;
            end
            else if (pci == `PCI_FIRST)
            begin
              rx_len_reg <= rxf_reg[15:8];
              rx_cnt_reg <= 8'd6;
              for (i = 0; i < 6; i = i + 1)
                buf_reg[i] <= rxf_reg[8*i+16 +: 8];
              // flow control frame: continue, block 0, 1 ms gap
              txf_reg <= {40'h0, `FC_STMIN_MS, `FC_BLOCK, `FC_CTS};
              tx_valid_reg   <= 1'b1;
              fc_pending_reg <= 1'b1;
              state_reg      <= S_FLOW;
            end
          end
        end
        // receive consecutive frames of a segmented command
        S_FLOW:
        begin
          if (ctl && pwdata[`CTRL_TX_DONE])
            tx_valid_reg <= 1'b0;
          if (ctl && pwdata[`CTRL_RX_PUSH] && pci == `PCI_CONSEC)
          begin
            for (i = 0; i < 7; i = i + 1)
              if (rx_cnt_reg + i < MAX_LEN)
                buf_reg[rx_cnt_reg + i] <= rxf_reg[8*i+8 +: 8];
            rx_cnt_reg <= rx_cnt_reg + 8'd7;
            if (rx_cnt_reg + 8'd7 >= rx_len_reg)
            begin
              fc_pending_reg <= 1'b0;
              state_reg      <= S_EXEC;
            end
          end
        end
        // software executes and reports; header length is validated here
        S_EXEC:
        begin
          if (rx_len_reg < 8'd4)
            err_reg <= `ERR_HEADER;
          else
            err_reg <= `ERR_NONE;
          if (ctl && (pwdata[`CTRL_EXEC_DONE] | pwdata[`CTRL_EXEC_FAIL]))
          begin
            pend_cmd_reg <= cmd;
            pend_id_reg  <= word_in;
            buf_reg[1]   <= `ACT_RET;
            buf_reg[3]   <= `RESERVED_BYTE;
            if (pwdata[`CTRL_EXEC_FAIL] || rx_len_reg < 8'd4)
            begin
              // failed command: header only, nothing applied
              buf_reg[2] <= (rx_len_reg < 8'd4) ? `ERR_HEADER : pwdata[15:8];
              tx_len_reg <= `NEG_LEN;
              pend_cmd_reg <= 8'hFF;
            end
            else
            begin
              buf_reg[2] <= `ERR_NONE;
              tx_len_reg <= pwdata[23:16];
              for (i = 0; i < 4; i = i + 1)
                buf_reg[4 + i] <= data0_reg[8*i +: 8];
              for (i = 0; i < 4; i = i + 1)
                buf_reg[8 + i] <= data1_reg[8*i +: 8];
            end
            tx_pos_reg <= 8'h0;
            seq_reg    <= 4'h1;
            state_reg  <= S_SEND;
          end
        end
        // stage one frame; responses keep the old ids until done
        S_SEND:
        begin
          txf_reg      <= frame_at(tx_pos_reg, tx_len_reg, seq_reg);
          tx_valid_reg <= 1'b1;
          state_reg    <= S_WAIT;
        end
        S_WAIT:
        begin
          if (ctl && pwdata[`CTRL_TX_DONE])
          begin
            tx_valid_reg <= 1'b0;
            if (tx_len_reg <= 8'd7)
              state_reg <= S_APPLY;
            else if (tx_pos_reg == 8'd0)
            begin
              tx_pos_reg <= 8'd6;
              state_reg  <= S_HOSTFC; // wait for host flow control
            end
            else if (tx_pos_reg + 8'd7 >= tx_len_reg)
              state_reg <= S_APPLY;
            else
            begin
              tx_pos_reg <= tx_pos_reg + 8'd7;
              seq_reg    <= seq_reg + 4'h1;
              state_reg  <= S_SEND;
            end
          end
        end
        // host flow control after our first frame; bs 0 means no more waits
        S_HOSTFC:
        begin
          if (ctl && pwdata[`CTRL_RX_PUSH] && pci == `PCI_FLOW)
            state_reg <= S_SEND;
        end
        // response is out: now apply deferred effects
        S_APPLY:
        begin
          if (pend_cmd_reg == `CMD_LOCAL_ID)
            active_local_id <= pend_id_reg;
          if (pend_cmd_reg == `CMD_REMOTE_ID)
            active_remote_id <= pend_id_reg;
          if (pend_cmd_reg == `CMD_BITRATE && rx_len_reg > 8'd4)
            active_bitrate <= pend_id_reg;
          restart_req <= (pend_cmd_reg == `CMD_RESTART);
          state_reg   <= S_RX;
        end
        default:
          state_reg <= S_RX;
      endcase
    end
  end

endmodule

// *** sim/responder_sva.sv ***
// Purpose: concurrent checks on the responder ports
// Assumes: one clock, asynchronous active low reset
// Notes:   id and restart changes must follow a frame-sent write
`timescale 1ns/10ps
`include "responder_map.vh"
module responder_sva
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        restart_req,
  input wire [31:0] active_local_id,
  input wire [31:0] active_remote_id,
  input wire [31:0] active_bitrate
);
  reg [3:0] since_reg;
  // cycles since the last frame-sent write; saturates so it never wraps
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      since_reg <= 4'hF;
    else if (psel && penable && pwrite && paddr == `OFF_CTRL && pwdata[`CTRL_TX_DONE])
      since_reg <= 4'h0;
    else if (since_reg != 4'hF)
      since_reg <= since_reg + 4'h1;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  ready_late_a: assert property ($rose(penable) && psel |=> pready) else $error("no pready");
  ready_early_a: assert property (psel && !penable |-> !pready ##1 !pready)
    else $error("early pready");
  ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
  err_ready_a: assert property (pslverr |-> pready) else $error("lone pslverr");
  err_unmap_a: assert property (pready && !$past(pwrite) && $past(paddr) > 8'h30 |-> pslverr)
    else $error("no pslverr");
  restart_once_a: assert property (restart_req |=> !restart_req) else $error("restart held");
  restart_late_a: assert property (restart_req |-> since_reg <= 4'h3)
    else $error("restart early");
  local_hold_a: assert property ($changed(active_local_id) |-> since_reg <= 4'h3)
    else $error("local id moved");
  remote_hold_a: assert property ($changed(active_remote_id) |-> since_reg <= 4'h3)
    else $error("remote id moved");
  rate_hold_a: assert property ($changed(active_bitrate) |-> since_reg <= 4'h3)
    else $error("bitrate moved");
endmodule
bind can_command_responder responder_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .restart_req(restart_req),
  .active_local_id(active_local_id), .active_remote_id(active_remote_id),
  .active_bitrate(active_bitrate));

// *** sim/host_model.sv ***
// Purpose: host side model moving frames through apb
// Assumes: frames are given byte0 first in bits 63:56
// Notes:   every wait is bounded; a hang raises timeout
`timescale 1ns/10ps
`include "responder_map.vh"
module host_model
(
  input  wire        pclk,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [7:0]  paddr,
  output reg  [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  output reg         timeout
);
  reg [31:0] rd_q;
  // idle bus from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timeout = 1'b0;
  end
  // byte order swap between frame view and register words
  function [31:0] sw(input [31:0] x);
    sw = {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
  // one transfer; the request stays put until pready is sampled high
  task xfer(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n >= 20)
        timeout <= 1'b1;
      rd_q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // hand one received frame to the device
  task push(input [63:0] fr);
    begin
      xfer(1'b1, `OFF_RXFRAME_LO, sw(fr[63:32]));
      xfer(1'b1, `OFF_RXFRAME_HI, sw(fr[31:0]));
      xfer(1'b1, `OFF_CTRL, 32'h0000_0002);
    end
  endtask
  // host flow control: continue, block 0, no gap
  task flow;
    push(64'h3000_0000_0000_0000);
  endtask
  // wait for a staged frame and read it out
  task take(output [63:0] fr);
    integer n;
    begin
      n = 0;
      xfer(1'b0, `OFF_STATUS, 32'h0);
      while (rd_q[6] !== 1'b1 && n < 20)
      begin
        xfer(1'b0, `OFF_STATUS, 32'h0);
        n = n + 1;
      end
      if (n >= 20)
        timeout <= 1'b1;
      xfer(1'b0, `OFF_TXFRAME_LO, 32'h0);
      fr[63:32] = sw(rd_q);
      xfer(1'b0, `OFF_TXFRAME_HI, 32'h0);
      fr[31:0] = sw(rd_q);
    end
  endtask
endmodule

// *** sim/can_command_responder_tb.sv ***
// Purpose: self-checking bench for the command responder
// Assumes: host model drives apb; software role played here
// Notes:   response data limited to bytes 4..11 in these cases
`timescale 1ns/10ps
`include "responder_map.vh"
module can_command_responder_tb;
  typedef struct packed {logic [63:0] c; logic [7:0] l; logic [7:0] e; logic [63:0] x;} row_t;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  wire        psel;
  wire        penable;
  wire        pwrite;
  wire [7:0]  paddr;
  wire [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        restart_req;
  wire [31:0] lid;
  wire [31:0] rid;
  wire [31:0] brt;
  wire        timeout;
  reg  [63:0] f;
  row_t       rows [0:3];
  integer     error_cnt = 0;
  integer     n_tests = 0;
  integer     rst_cnt = 0;
  integer     i;
  always #5 pclk = ~pclk;
  can_command_responder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .restart_req(restart_req), .active_local_id(lid),
    .active_remote_id(rid), .active_bitrate(brt));
  host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .timeout(timeout));
  // count restart pulses so a missed or doubled one shows
  always @(posedge pclk)
    if (restart_req === 1'b1)
      rst_cnt <= rst_cnt + 1;
  always @(posedge timeout)
  begin
    error_cnt = error_cnt + 1;
    end_of_test;
  end
  task check(input [63:0] got, input [63:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  function [31:0] cur(input [7:0] c);
    cur = c == `CMD_LOCAL_ID ? lid : c == `CMD_REMOTE_ID ? rid : brt;
  endfunction
  // software ends execution: done with length, or fail with a code
  task exec(input [7:0] len, input [7:0] err, input [31:0] d0);
    begin
      u_host.xfer(1'b1, `OFF_DATA0, d0);
      if (err != 8'h00)
        u_host.xfer(1'b1, `OFF_CTRL, {16'h0000, err, 8'h08});
      else
        u_host.xfer(1'b1, `OFF_CTRL, {8'h00, len, 16'h0004});
    end
  endtask
  // eight byte set command in two frames, then its reply
  task set8(input [7:0] c, input [31:0] v, input [7:0] err);
    reg [31:0] old;
    integer    n;
    begin
      old = cur(c);
      u_host.push({16'h1008, c, 24'h010000, v[7:0], v[15:8]});
      u_host.take(f);
      check(f, 64'h3000_0100_0000_0000);
      // mark the flow control frame as sent so tx_valid is not left stale
      u_host.xfer(1'b1, `OFF_CTRL, 32'h1);
      u_host.push({8'h21, v[23:16], v[31:24], 40'h0});
      exec(8'h08, err, v);
      u_host.take(f);
      if (err != 8'h00)
        check(f, {8'h04, c, 8'h03, err, 32'h0});
      else
      begin
        check(f, {16'h1008, c, 24'h030000, v[7:0], v[15:8]});
        u_host.xfer(1'b1, `OFF_CTRL, 32'h1);
        u_host.flow;
        u_host.take(f);
        check(f, {8'h21, v[23:16], v[31:24], 40'h0});
        check(cur(c), old);
      end
      u_host.xfer(1'b1, `OFF_CTRL, 32'h1);
      n = 0;
      while (cur(c) !== (err != 8'h00 ? old : v) && n < 8)
      begin
        @(posedge pclk);
        n = n + 1;
      end
      check(cur(c), err != 8'h00 ? old : v);
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // single frame cases: command, length, error, expected reply frame
  initial
  begin
    rows[0] = '{64'h0505_0100_0001_0000, 8'h04, 8'h00, 64'h0405_0300_0000_0000};
    rows[1] = '{64'h0407_0000_0000_0000, 8'h04, 8'h03, 64'h0407_0303_0000_0000};
    rows[2] = '{64'h0404_0000_0000_0000, 8'h05, 8'h00, 64'h0504_0300_0007_0000};
    rows[3] = '{64'h0505_0100_0002_0000, 8'h04, 8'h05, 64'h0405_0305_0000_0000};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    check({lid, rid}, {`RST_LOCAL_ID, `RST_REMOTE_ID});
    check(brt, `RST_BITRATE);
    for (i = 0; i < 4; i = i + 1)
    begin
      u_host.push(rows[i].c);
      exec(rows[i].l, rows[i].e, 32'h0000_0007);
      u_host.take(f);
      check(f, rows[i].x);
      u_host.xfer(1'b1, `OFF_CTRL, 32'h1);
    end
    // eighteen byte reply: first frame, then consecutive frames 0x21 and 0x22
    u_host.push(64'h0402_0000_0000_0000);
    u_host.xfer(1'b1, `OFF_DATA1, 32'h4433_2211);
    exec(8'h12, 8'h00, 32'h5A5A_5A5A);
    u_host.take(f);
    check(f, 64'h1012_0203_0000_5A5A);
    u_host.xfer(1'b1, `OFF_CTRL, 32'h1);
    u_host.flow;
    u_host.take(f);
    check(f, 64'h215A_5A11_2233_4400);
    u_host.xfer(1'b1, `OFF_CTRL, 32'h1);
    u_host.take(f);
    check(f, 64'h2200_0000_0000_0000);
    u_host.xfer(1'b1, `OFF_CTRL, 32'h1);
    set8(`CMD_BITRATE, 32'h0000_03E8, 8'h00);
    // restart after a rate change; the pulse waits for the reply
    u_host.push(64'h0401_0200_0000_0000);
    exec(8'h04, 8'h00, 32'h0);
    u_host.take(f);
    check(f, 64'h0401_0300_0000_0000);
    check(rst_cnt, 0);
    u_host.xfer(1'b1, `OFF_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    set8(`CMD_LOCAL_ID, 32'h0000_0123, 8'h00);
    set8(`CMD_REMOTE_ID, 32'h0000_0456, 8'h00);
    set8(`CMD_LOCAL_ID, 32'h0000_0777, `ERR_RANGE);
    u_host.xfer(1'b0, 8'hFC, 32'h0);
    check(pslverr, 1'b1);
    check(rst_cnt, 1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check(lid, `RST_LOCAL_ID);
    check({rid, brt}, {`RST_REMOTE_ID, `RST_BITRATE});
    // after a mid-run reset the block is idle and waits for a command
    u_host.xfer(1'b0, `OFF_STATUS, 32'h0);
    check(u_host.rd_q, 32'h0);
    end_of_test;
  end
endmodule
